// [logic/mic_edge.sv]
`default_nettype none
module mic_edge #(
   parameter int W = 6
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         nrst,
   // Level in, edge pulses out.
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] prev;

   assign rise = din & ~prev;
   assign fall = ~din & prev;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev <= '0;
      end else begin
         prev <= din;
      end
   end
endmodule : mic_edge
`default_nettype wire

// [logic/mic_irq_ctrl.sv]
// The register addresses and the APB interface to the registers were decided locally.
`default_nettype none
module mic_irq_ctrl
   import mic_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              nrst,
   // APB slave.
   input  wire mic_apb_req_s      apb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Event sources.
   input  wire logic [PORT_W-1:0] io_port_a,
   input  wire logic [7:0]        timer_zero_count,
   input  wire logic [7:0]        periph_evt_one,
   input  wire logic [7:0]        periph_evt_two,
   // Core side.
   input  wire mic_core_s         core,
   input  wire mic_rst_cause_s    rst_cause,
   output logic                   pc_load,
   output logic [PC_W-1:0]        pc_value,
   output logic                   push_ret,
   output logic                   pop_ret,
   output logic                   wake,
   output logic [4:0]             status_bits,
   output logic [1:0]             power_control_reg,
   output logic [PORT_W-1:0]      port_output_latch
);
   mic_qph_e          phase;
   logic              q1;
   logic [7:0]        irq_control_status;
   logic [7:0]        periph_irq_flags_one;
   logic [7:0]        periph_irq_enable_one;
   logic [7:0]        periph_irq_flags_two;
   logic [7:0]        periph_irq_enable_two;
   logic [PORT_W-1:0] pin_change_flags;
   logic [PORT_W-1:0] pin_change_fall_enable;
   logic [PORT_W-1:0] pin_change_rise_enable;
   logic [PORT_W-1:0] analog_select_reg;
   logic              ext_edge_select;
   logic [7:0]        t0_prev;
   mic_seq_e          seq;
   logic [1:0]        lat_cnt;

   mic_qphase u_qphase (
      .clk   (clk),
      .nrst  (nrst),
      .phase (phase),
      .q1    (q1)
   );

   // Analog pins are forced low before any edge logic sees them.
   wire [PORT_W-1:0] pin_dig = io_port_a & ~analog_select_reg;
   wire [PORT_W-1:0] pin_rise;
   wire [PORT_W-1:0] pin_fall;

   mic_edge #(.W(PORT_W)) u_edge (
      .clk  (clk),
      .nrst (nrst),
      .din  (pin_dig),
      .rise (pin_rise),
      .fall (pin_fall)
   );

   // Bus decode.
   wire       wr_go   = apb.psel & apb.penable & pready & apb.pwrite;
   wire       setup   = apb.psel & ~apb.penable;
   wire [7:0] wd      = apb.pwdata[7:0];
   wire       s_ctl   = (apb.paddr == OFS_CTL);
   wire       s_pfl1  = (apb.paddr == OFS_PFL1);
   wire       s_pen1  = (apb.paddr == OFS_PEN1);
   wire       s_pfl2  = (apb.paddr == OFS_PFL2);
   wire       s_pen2  = (apb.paddr == OFS_PEN2);
   wire       s_iocf  = (apb.paddr == OFS_IOCF);
   wire       s_iocn  = (apb.paddr == OFS_IOCN);
   wire       s_iocp  = (apb.paddr == OFS_IOCP);
   wire       s_lat   = (apb.paddr == OFS_LAT);
   wire       s_ana   = (apb.paddr == OFS_ANA);
   wire       s_cfg   = (apb.paddr == OFS_CFG);
   wire       s_port  = (apb.paddr == OFS_PORT);
   wire       s_stat  = (apb.paddr == OFS_STATUS);
   wire       s_pwr   = (apb.paddr == OFS_PWR);
   wire       mapped  = s_ctl | s_pfl1 | s_pen1 | s_pfl2 | s_pen2 | s_iocf | s_iocn
                      | s_iocp | s_lat | s_ana | s_cfg | s_port | s_stat | s_pwr;

   // Resets other than power-on act synchronously; wake-ups are not resets.
   wire soft_rst = rst_cause.mclr_run | rst_cause.mclr_sleep | rst_cause.wdt_reset
                 | rst_cause.bor;

   // Event detection.
   wire ext_edge = ext_edge_select ? pin_rise[EXT_PIN] : pin_fall[EXT_PIN];
   wire t0_wrap  = (t0_prev == T0_MAX) && (timer_zero_count == 8'h00);
   // A change in the same cycle as a port access is dropped, as the part allows.
   wire [PORT_W-1:0] ioc_set = ((pin_rise & pin_change_rise_enable)
                              | (pin_fall & pin_change_fall_enable))
                              & ~{PORT_W{core.port_access}};
   wire ioc_any = |pin_change_flags;

   wire gen  = irq_control_status[B_GEN];
   wire grp  = irq_control_status[B_GRP];
   wire periph_hit = |(periph_irq_flags_one & periph_irq_enable_one)
                   | |(periph_irq_flags_two & periph_irq_enable_two);
   // Each source needs its own enable; flag bits themselves ignore enables.
   wire any_enabled = (irq_control_status[B_TOVE] & irq_control_status[B_TOVF])
                    | (irq_control_status[B_EXTE] & irq_control_status[B_EXTF])
                    | (irq_control_status[B_PCHE] & ioc_any)
                    | (grp & periph_hit);
   wire request = gen & any_enabled;

   // Sequencer, stepped once per instruction cycle at Q1.
   wire do_vector = q1 && (seq == SEQ_LAT) && gen && (lat_cnt == LAT_TCY);
   wire do_wake   = q1 && (seq == SEQ_IDLE) && core.sleeping && any_enabled;
   mic_seq_e   next_seq;
   logic [1:0] next_lat_cnt;

   always_comb begin
      next_seq     = seq;
      next_lat_cnt = lat_cnt;
      if (soft_rst) begin
         next_seq     = SEQ_IDLE;
         next_lat_cnt = 2'h0;
      end else if (q1) begin
         unique case (seq)
            SEQ_IDLE: begin
               if (core.sleeping) begin
                  // Woken with the global enable set: run PC+1 before vectoring.
                  if (any_enabled && gen) begin
                     next_seq = SEQ_WAKE;
                  end
               end else if (request) begin
                  next_seq     = SEQ_LAT;
                  next_lat_cnt = 2'h1;
               end
            end
            SEQ_WAKE: begin
               next_seq     = gen ? SEQ_LAT : SEQ_IDLE;
               next_lat_cnt = 2'h1;
            end
            SEQ_LAT: begin
               // A cleared enable abandons the entry; the flags stay pending.
               if (!gen || do_vector) begin
                  next_seq = SEQ_IDLE;
               end else begin
                  next_lat_cnt = lat_cnt + 2'h1;
               end
            end
            default: begin
               next_seq = SEQ_IDLE;
            end
         endcase
      end
   end

   // Control register next value; hardware sets win over software clears.
   wire [7:0] ctl_wr = (wr_go && s_ctl) ? wd : irq_control_status;
   logic      next_gen;

   always_comb begin
      next_gen = ctl_wr[B_GEN];
      if (core.return_from_irq_instr) begin
         next_gen = 1'b1;
      end
      if (do_vector || soft_rst) begin
         next_gen = 1'b0;
      end
   end

   wire [7:0] next_ctl = {next_gen, ctl_wr[6:3],
                          ctl_wr[B_TOVF] | t0_wrap,
                          ctl_wr[B_EXTF] | ext_edge,
                          ioc_any};

   // Status bits 7:3 and power control follow the cause.
   logic [4:0] next_status;
   logic [1:0] next_pwr;

   always_comb begin
      next_status = status_bits;
      next_pwr    = (wr_go && s_pwr) ? wd[1:0] : power_control_reg;
      if (rst_cause.bor) begin
         next_status  = 5'h03;
         next_pwr[0]  = 1'b0;
      end else if (rst_cause.wdt_reset) begin
         next_status = {4'h0, status_bits[0]};
      end else if (rst_cause.mclr_sleep) begin
         next_status = 5'h02;
      end else if (rst_cause.mclr_run) begin
         next_status = {3'h0, status_bits[1:0]};
      end else if (rst_cause.wdt_wake) begin
         next_status = {status_bits[4:2], 2'h0};
      end else if (do_wake) begin
         next_status = {status_bits[4:2], 2'h2};
      end
   end

   // Read path.
   wire [7:0] rd_mux = s_ctl   ? irq_control_status :
                       s_pfl1  ? periph_irq_flags_one :
                       s_pen1  ? periph_irq_enable_one :
                       s_pfl2  ? periph_irq_flags_two :
                       s_pen2  ? periph_irq_enable_two :
                       s_iocf  ? {2'h0, pin_change_flags} :
                       s_iocn  ? {2'h0, pin_change_fall_enable} :
                       s_iocp  ? {2'h0, pin_change_rise_enable} :
                       s_lat   ? {2'h0, port_output_latch} :
                       s_ana   ? {2'h0, analog_select_reg} :
                       s_cfg   ? {7'h00, ext_edge_select} :
                       s_port  ? {2'h0, pin_dig} :
                       s_stat  ? {status_bits, 3'h0} :
                       s_pwr   ? {6'h00, power_control_reg} : 8'h00;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   // Registers returned to their reset values by every reset cause; the latch keeps its value except at power-on.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_control_status     <= CTL_RST;
         periph_irq_flags_one   <= 8'h00;
         periph_irq_enable_one  <= 8'h00;
         periph_irq_flags_two   <= 8'h00;
         periph_irq_enable_two  <= 8'h00;
         pin_change_flags       <= '0;
         pin_change_fall_enable <= '0;
         pin_change_rise_enable <= '0;
         analog_select_reg      <= ANA_RST;
         ext_edge_select        <= EDGE_SEL_RST;
      end else if (soft_rst) begin
         irq_control_status     <= CTL_RST;
         periph_irq_flags_one   <= 8'h00;
         periph_irq_enable_one  <= 8'h00;
         periph_irq_flags_two   <= 8'h00;
         periph_irq_enable_two  <= 8'h00;
         pin_change_flags       <= '0;
         pin_change_fall_enable <= '0;
         pin_change_rise_enable <= '0;
         analog_select_reg      <= ANA_RST;
         ext_edge_select        <= EDGE_SEL_RST;
      end else begin
         irq_control_status     <= next_ctl;
         periph_irq_flags_one   <= (((wr_go && s_pfl1) ? wd : periph_irq_flags_one)
                                   | periph_evt_one) & PFL1_MASK;
         periph_irq_flags_two   <= ((wr_go && s_pfl2) ? wd : periph_irq_flags_two)
                                   | periph_evt_two;
         pin_change_flags       <= ((wr_go && s_iocf) ? wd[PORT_W-1:0] : pin_change_flags)
                                   | ioc_set;
         if (wr_go && s_pen1) begin
            periph_irq_enable_one <= wd & PFL1_MASK;
         end
         if (wr_go && s_pen2) begin
            periph_irq_enable_two <= wd;
         end
         if (wr_go && s_iocn) begin
            pin_change_fall_enable <= wd[PORT_W-1:0];
         end
         if (wr_go && s_iocp) begin
            pin_change_rise_enable <= wd[PORT_W-1:0];
         end
         if (wr_go && s_ana) begin
            analog_select_reg <= wd[PORT_W-1:0] & LAT_MASK;
         end
         if (wr_go && s_cfg) begin
            ext_edge_select <= wd[0];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_output_latch <= '0;
         t0_prev           <= 8'h00;
         status_bits       <= STATUS_POR;
         power_control_reg <= PWR_POR;
         seq               <= SEQ_IDLE;
         lat_cnt           <= 2'h0;
      end else begin
         if (wr_go && s_lat) begin
            port_output_latch <= wd[PORT_W-1:0] & LAT_MASK;
         end
         t0_prev           <= timer_zero_count;
         status_bits       <= next_status;
         power_control_reg <= next_pwr;
         seq               <= next_seq;
         lat_cnt           <= next_lat_cnt;
      end
   end

   // Core strobes. Only the return address is saved; working state is software's job.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_load  <= 1'b1;
         pc_value <= RESET_PC;
         push_ret <= 1'b0;
         pop_ret  <= 1'b0;
         wake     <= 1'b0;
      end else begin
         pc_load  <= do_vector | soft_rst;
         pc_value <= soft_rst ? RESET_PC : VECTOR_PC;
         push_ret <= do_vector & ~soft_rst;
         pop_ret  <= core.return_from_irq_instr;
         wake     <= do_wake;
      end
   end
endmodule : mic_irq_ctrl
`default_nettype wire

// [logic/mic_pkg.sv]
// Notes on behaviour
// - Global enable passes enabled requests, else blocks.
// - Every reset clears the global enable.
// - Service clears enable, pushes return, vectors 0004h.
// - Return from interrupt pops and re-enables globally.
// - Flags set regardless of any enable bit.
// - Clearing global enable drops requests still in flight.
// - Latency three Tcy synchronous, three-four asynchronous.
// - External pin edge selectable, valid edge sets flag.
// - Pin enable masks source; enabled edge wakes sleep.
// - Analog pins read zero, raise no requests.
// - Timer count wrap FFh to 00h sets flag.
// - Enabled port pin change sets pin-change flag.
// - Pin change during port access may be lost.
// - External flag set Q4-Q1, sampled each Q1.
// - Peripheral flags and enables in separate registers.
// - Wake with enable set runs PC+1, then vectors.
// - Status bits follow reset or wake cause.
// - Power-control bit 0 cleared only by brown-out.
// - Hardware saves only return address on entry.
`default_nettype none
package mic_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          PC_W          = 13;
   localparam int          PORT_W        = 6;
   // Register byte offsets.
   localparam logic [7:0]  OFS_CTL       = 8'h00;
   localparam logic [7:0]  OFS_PFL1      = 8'h04;
   localparam logic [7:0]  OFS_PEN1      = 8'h08;
   localparam logic [7:0]  OFS_PFL2      = 8'h0c;
   localparam logic [7:0]  OFS_PEN2      = 8'h10;
   localparam logic [7:0]  OFS_IOCF      = 8'h14;
   localparam logic [7:0]  OFS_IOCN      = 8'h18;
   localparam logic [7:0]  OFS_IOCP      = 8'h1c;
   localparam logic [7:0]  OFS_LAT       = 8'h20;
   localparam logic [7:0]  OFS_ANA       = 8'h24;
   localparam logic [7:0]  OFS_CFG       = 8'h28;
   localparam logic [7:0]  OFS_PORT      = 8'h2c;
   localparam logic [7:0]  OFS_STATUS    = 8'h30;
   localparam logic [7:0]  OFS_PWR       = 8'h34;
   // Control register bit positions.
   localparam int          B_GEN         = 7;
   localparam int          B_GRP         = 6;
   localparam int          B_TOVE        = 5;
   localparam int          B_EXTE        = 4;
   localparam int          B_PCHE        = 3;
   localparam int          B_TOVF        = 2;
   localparam int          B_EXTF        = 1;
   localparam int          B_PCHF        = 0;
   localparam int          EXT_PIN       = 2;
   // Implemented bit masks and reset values.
   localparam logic [7:0]  PFL1_MASK     = 8'hc7;
   localparam logic [5:0]  LAT_MASK      = 6'h37;
   localparam logic [5:0]  ANA_RST       = 6'h37;
   localparam logic [7:0]  CTL_RST       = 8'h00;
   localparam logic        EDGE_SEL_RST  = 1'b1;
   localparam logic [4:0]  STATUS_POR    = 5'h03;
   localparam logic [1:0]  PWR_POR       = 2'h0;
   localparam logic [7:0]  T0_MAX        = 8'hff;
   localparam logic [PC_W-1:0] VECTOR_PC = 13'h0004;
   localparam logic [PC_W-1:0] RESET_PC  = 13'h0000;
   // Timing: four clocks per instruction cycle, three cycles from sample to vector.
   localparam int          CLK_NS        = 8;
   localparam int          QPH_PER_TCY   = 4;
   localparam int          TCY_NS        = CLK_NS * QPH_PER_TCY;
   localparam logic [1:0]  LAT_TCY       = 2'h3;

   typedef enum logic [1:0] {
      QPH_1 = 2'b00,
      QPH_2 = 2'b01,
      QPH_3 = 2'b10,
      QPH_4 = 2'b11
   } mic_qph_e;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_LAT  = 2'b01,
      SEQ_WAKE = 2'b10
   } mic_seq_e;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } mic_apb_req_s;

   typedef struct packed {
      logic mclr_run;
      logic mclr_sleep;
      logic wdt_reset;
      logic bor;
      logic wdt_wake;
   } mic_rst_cause_s;

   typedef struct packed {
      logic return_from_irq_instr;
      logic port_access;
      logic sleeping;
   } mic_core_s;
endpackage : mic_pkg
`default_nettype wire

// [logic/mic_qphase.sv]
`default_nettype none
module mic_qphase
   import mic_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic nrst,
   // Phase outputs.
   output mic_qph_e  phase,
   output logic      q1
);
   mic_qph_e next_phase;

   assign next_phase = mic_qph_e'(phase + 2'h1);
   assign q1         = (phase == QPH_1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase <= QPH_1;
      end else begin
         phase <= next_phase;
      end
   end
endmodule : mic_qphase
`default_nettype wire

// [test/mic_core_model.sv]
`default_nettype none
module mic_core_model #(
   parameter int RET_DLY = 40
) (
   // Clock and reset.
   input  wire logic  clk,
   input  wire logic  nrst,
   // Controller side.
   input  wire logic  push_ret,
   input  wire logic  pop_ret,
   output logic       ret,
   output logic [3:0] depth
);
   timeunit 1ns;
   timeprecision 100ps;
   // The routine runs a fixed time, long enough for the bench to clear its flag first.
   logic [7:0] cnt;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt   <= 8'h00;
         ret   <= 1'b0;
         depth <= 4'h0;
      end else begin
         ret <= 1'b0;
         if (push_ret) begin
            cnt   <= 8'h01;
            depth <= depth + 4'h1;
         end else if (pop_ret) begin
            depth <= depth - 4'h1;
         end
         if (!push_ret && cnt == 8'(RET_DLY)) begin
            cnt <= 8'h00;
            ret <= 1'b1;
         end else if (!push_ret && cnt != 8'h00) begin
            cnt <= cnt + 8'h01;
         end
      end
   end
endmodule : mic_core_model
`default_nettype wire

// [test/mic_irq_ctrl_sva.sv]
`default_nettype none
module mic_irq_ctrl_sva
   import mic_pkg::*;
(
   // Clock and reset.
   input wire logic            clk,
   input wire logic            nrst,
   // Core side.
   input wire mic_core_s       core,
   input wire mic_rst_cause_s  rst_cause,
   input wire logic            pc_load,
   input wire logic [PC_W-1:0] pc_value,
   input wire logic            push_ret,
   input wire logic            pop_ret,
   input wire logic            wake,
   input wire logic [4:0]      status_bits,
   input wire logic [1:0]      power_control_reg
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   wire soft_rst = rst_cause.mclr_run | rst_cause.mclr_sleep | rst_cause.wdt_reset
                   | rst_cause.bor;
   sequence s_vector;
      pc_load && pc_value == VECTOR_PC;
   endsequence
   sequence s_restart;
      pc_load && pc_value == RESET_PC && !push_ret;
   endsequence
   property p_vector;
      push_ret |-> s_vector;
   endproperty
   a_vector: assert property (p_vector)
      else $error("entry without vector load");
   // Entry drops the global enable, so a second entry needs a full latency first.
   property p_spacing;
      push_ret |=> !push_ret [*8];
   endproperty
   a_spacing: assert property (p_spacing)
      else $error("entries too close together");
   property p_return;
      core.return_from_irq_instr |=> pop_ret;
   endproperty
   a_return: assert property (p_return)
      else $error("return without pop");
   property p_pop_cause;
      pop_ret |-> $past(core.return_from_irq_instr);
   endproperty
   a_pop_cause: assert property (p_pop_cause)
      else $error("pop without return");
   property p_soft;
      soft_rst |=> s_restart;
   endproperty
   a_soft: assert property (p_soft)
      else $error("reset did not restart");
   property p_bor;
      rst_cause.bor |=> status_bits == 5'h03 && !power_control_reg[0];
   endproperty
   a_bor: assert property (p_bor)
      else $error("brown-out values wrong");
   property p_pwr_keep;
      soft_rst && !rst_cause.bor |=> power_control_reg[0] == $past(power_control_reg[0]);
   endproperty
   a_pwr_keep: assert property (p_pwr_keep)
      else $error("power bit lost");
   property p_wdt;
      rst_cause.wdt_reset |=> status_bits[4:1] == 4'h0 && $stable(status_bits[0]);
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog status wrong");
   property p_wake;
      wake |-> $past(core.sleeping);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake while awake");
endmodule : mic_irq_ctrl_sva
bind mic_irq_ctrl mic_irq_ctrl_sva u_sva (.clk(clk), .nrst(nrst), .core(core),
   .rst_cause(rst_cause), .pc_load(pc_load), .pc_value(pc_value), .push_ret(push_ret),
   .pop_ret(pop_ret), .wake(wake), .status_bits(status_bits),
   .power_control_reg(power_control_reg));
`default_nettype wire

// [test/mic_irq_ctrl_tb_top.sv]
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (x)); end end
module mic_irq_ctrl_tb_top
   import mic_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic              clk, nrst, pready, pslverr, e, pc_load, push_ret, pop_ret, wake;
   logic              ret, slp, of;
   mic_apb_req_s      apb;
   mic_rst_cause_s    rc;
   mic_core_s         core;
   logic [31:0]       prdata, r;
   logic [PORT_W-1:0] pins, latch;
   logic [7:0]        tmr, ev1, x;
   logic [PC_W-1:0]   pc_value;
   logic [4:0]        status_bits, est;
   logic [1:0]        pwr, pc;
   logic [3:0]        depth;
   logic [15:0]       rnd;
   int                bad_count, checks_done, k, c;
   assign core = '{ret, 1'b0, slp};
   always #4 clk = ~clk;
   mic_irq_ctrl DUT (.clk(clk), .nrst(nrst), .apb(apb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .io_port_a(pins), .timer_zero_count(tmr), .periph_evt_one(ev1),
      .periph_evt_two(8'h00), .core(core), .rst_cause(rc), .pc_load(pc_load),
      .pc_value(pc_value), .push_ret(push_ret), .pop_ret(pop_ret), .wake(wake),
      .status_bits(status_bits), .power_control_reg(pwr), .port_output_latch(latch));
   mic_core_model #(.RET_DLY(40)) u_core (.clk(clk), .nrst(nrst), .push_ret(push_ret),
      .pop_ret(pop_ret), .ret(ret), .depth(depth));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [4:0] exp_st(input int n, input logic [4:0] s);
      case (n)
         0: return s & 5'h03;
         1: return 5'h02;
         2: return s & 5'h01;
         3: return 5'h03;
         default: return s & 5'h1c;
      endcase
   endfunction : exp_st
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      apb <= '0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
      xfer(1'b0, a, 32'h0);
      `CHK(r & {24'h0, m}, {24'h0, v})
   endtask : chk_rd
   task automatic pin(input int b, input logic v);
      @(posedge clk);
      pins[b] <= v;
   endtask : pin
   // Returns the cycle count of the first pulse, or -1 when none came within the limit.
   task automatic wait_sig(input int lim, input int sel, output int n);
      logic s;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         s = (sel == 0) ? push_ret : (sel == 1) ? wake : pop_ret;
         n++;
      end while (s !== 1'b1 && n < lim);
      if (s !== 1'b1) n = -1;
   endtask : wait_sig
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      apb = '0;
      rc = '0;
      pins = '0;
      tmr = 8'h00;
      ev1 = 8'h00;
      slp = 1'b0;
      of = 1'b0;
      rnd = 16'd23562;
      bad_count = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      chk_rd(8'h00, 8'hff, 8'h00);
      chk_rd(8'h24, 8'hff, 8'h37);
      chk_rd(8'h30, 8'hff, 8'h18);
      chk_rd(8'h34, 8'hff, 8'h00);
      xfer(1'b0, 8'h3c, 32'h0);
      `CHK({e, r}, {1'b1, 32'h0})
      repeat (3) begin
         rnd = lfsr(rnd);
         wr(8'h20, rnd[7:0]);
         chk_rd(8'h20, 8'hff, rnd[7:0] & 8'h37);
         `CHK(latch, rnd[5:0] & 6'h37)
      end
      wr(8'h34, 8'h03);
      est = 5'h03;
      pc = 2'h3;
      for (k = 0; k < 5; k++) begin
         wr(8'h00, 8'h40);
         @(posedge clk);
         rc <= mic_rst_cause_s'(5'h10 >> k);
         @(posedge clk);
         rc <= '0;
         @(posedge clk);
         #1;
         est = exp_st(k, est);
         if (k == 3) pc[0] = 1'b0;
         `CHK(status_bits, est)
         `CHK(pwr, pc)
         chk_rd(8'h00, 8'hff, (k == 4) ? 8'h40 : 8'h00);
      end
      wr(8'h24, 8'h00);
      for (k = 0; k < 2; k++) begin
         wr(8'h28, 8'(k));
         pin(2, !k);
         chk_rd(8'h00, 8'h02, 8'h00);
         pin(2, k);
         chk_rd(8'h00, 8'h02, 8'h02);
         wr(8'h00, 8'h00);
      end
      wr(8'h24, 8'h04);
      pin(2, 1'b0);
      pin(2, 1'b1);
      chk_rd(8'h00, 8'h02, 8'h00);
      chk_rd(8'h2c, 8'h04, 8'h00);
      wr(8'h24, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h1c, 8'h01);
      pin(0, 1'b1);
      chk_rd(8'h14, 8'hff, 8'h01);
      chk_rd(8'h00, 8'h01, 8'h01);
      wr(8'h14, 8'h00);
      repeat (24) begin
         rnd = lfsr(rnd);
         of |= (tmr == 8'hff && rnd[7:0] == 8'h00);
         @(posedge clk);
         tmr <= rnd[7:0];
      end
      chk_rd(8'h00, 8'h04, {5'h0, of, 2'h0});
      @(posedge clk);
      tmr <= 8'hff;
      @(posedge clk);
      tmr <= 8'h00;
      chk_rd(8'h00, 8'h04, 8'h04);
      pin(2, 1'b0);
      wr(8'h00, 8'h90);
      pin(2, 1'b1);
      wait_sig(40, 0, c);
      `CHK(c >= 3 * QPH_PER_TCY && c <= 4 * QPH_PER_TCY + 3, 1'b1)
      `CHK(pc_value, VECTOR_PC)
      chk_rd(8'h00, 8'h80, 8'h00);
      wr(8'h00, 8'h10);
      wait_sig(80, 2, c);
      `CHK(c > 0, 1'b1)
      chk_rd(8'h00, 8'h80, 8'h80);
      wait_sig(40, 0, c);
      `CHK(c, -1)
      `CHK(depth, 4'h0)
      pin(2, 1'b0);
      pin(2, 1'b1);
      wr(8'h00, 8'h12);
      wait_sig(30, 0, c);
      `CHK(c, -1)
      chk_rd(8'h00, 8'h02, 8'h02);
      wr(8'h00, 8'h92);
      wait_sig(30, 0, c);
      `CHK(c > 0, 1'b1)
      wr(8'h00, 8'h10);
      wait_sig(80, 2, c);
      wr(8'h08, 8'h01);
      wr(8'h00, 8'h80);
      rnd = lfsr(rnd);
      x = rnd[7:0] | 8'h01;
      @(posedge clk);
      ev1 <= x;
      @(posedge clk);
      ev1 <= 8'h00;
      wait_sig(30, 0, c);
      `CHK(c, -1)
      chk_rd(8'h04, 8'hff, x & 8'hc7);
      wr(8'h00, 8'hc0);
      wait_sig(30, 0, c);
      `CHK(c > 0, 1'b1)
      wr(8'h04, 8'h00);
      wait_sig(80, 2, c);
      wr(8'h00, 8'h10);
      slp <= 1'b1;
      pin(2, 1'b0);
      pin(2, 1'b1);
      wait_sig(30, 1, c);
      slp <= 1'b0;
      `CHK(c > 0, 1'b1)
      est = {est[4:2], 2'b10};
      `CHK(status_bits, est)
      wait_sig(30, 0, c);
      `CHK(c, -1)
      wr(8'h00, 8'h00);
      slp <= 1'b1;
      pin(2, 1'b0);
      pin(2, 1'b1);
      wait_sig(30, 1, c);
      `CHK(c, -1)
      wrap_up();
   end
endmodule : mic_irq_ctrl_tb_top
`default_nettype wire
